/* File: design/fwsp_poller.sv */
`timescale 1ns/100ps
`include "fwsp_consts.svh"
module fwsp_poller
   import fwsp_pkg::*;
#(
   parameter int RD_CYC = `FWSP_RD_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [31:0] sw_rdata,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [21:0] flash_addr,
   output logic [7:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [7:0] flash_dq_in,
   input wire logic ready_busy_output
);
   fwsp_state_e st_reg, st_next;
   fwsp_bus_s bus_reg, bus_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [7:0] first_reg, first_next;
   logic [7:0] last_reg, last_next;
   logic [21:0] addr_reg, addr_next;
   logic pass_reg, pass_next, fail_reg, fail_next;
   logic tmr_reg, tmr_next, rej_reg, rej_next, rdy_reg, rdy_next;
   logic [31:0] rdata_reg, rdata_next;
   logic cycle_end;

   // true when the toggle bit differs between two samples
   function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
      return a[`FWSP_BIT_TOG1] != b[`FWSP_BIT_TOG1];
   endfunction

   // start a fresh bus cycle: read or write
   function automatic fwsp_bus_s cyc(input logic wr, input logic [21:0] a,
                                     input logic [7:0] d);
      fwsp_bus_s b;
      b.ce_n = 1'b0;
      b.oe_n = wr;
      b.we_n = !wr;
      b.addr = a;
      b.dout = d;
      b.dout_en = wr;
      return b;
   endfunction

   localparam fwsp_bus_s BUS_IDLE = '{1'b1, 1'b1, 1'b1, 22'h0, 8'h0, 1'b0};

   assign cycle_end = (cnt_reg == 8'(RD_CYC - 1));

   // polling sequencer next state
   always_comb begin
      st_next = st_reg;
      bus_next = bus_reg;
      cnt_next = cycle_end ? 8'h0 : cnt_reg + 8'h1;
      first_next = first_reg;
      last_next = last_reg;
      addr_next = addr_reg;
      pass_next = pass_reg;
      fail_next = fail_reg;
      tmr_next = tmr_reg;
      rej_next = rej_reg;
      rdy_next = ready_busy_output;
      if (st_reg == FWSP_IDLE) begin
         cnt_next = 8'h0;
      end
      unique case (st_reg)
         FWSP_IDLE: begin
            bus_next = BUS_IDLE;
            if (sw_wr && sw_addr == `FWSP_OFF_CTRL) begin
               pass_next = 1'b0;
               fail_next = 1'b0;
               rej_next = 1'b0;
               if (sw_wdata[`FWSP_CTRL_GO]) begin
                  // first of two reads at the status address
                  st_next = FWSP_RD1;
                  bus_next = cyc(1'b0, addr_reg, 8'h0);
               end else if (sw_wdata[`FWSP_CTRL_TIMER]) begin
                  // sample timer bit before adding a sector
                  // the window length is never assumed, always read
                  st_next = FWSP_TMR_RD;
                  bus_next = cyc(1'b0, addr_reg, 8'h0);
               end
            end
         end
         FWSP_RD1, FWSP_RECHK1: if (cycle_end) begin
            first_next = flash_dq_in;
            st_next = (st_reg == FWSP_RD1) ? FWSP_RD2 : FWSP_RECHK2;
            bus_next = cyc(1'b0, addr_reg, 8'h0);
         end
         FWSP_RD2: if (cycle_end) begin
            last_next = flash_dq_in;
            bus_next = cyc(1'b0, addr_reg, 8'h0);
            if (!toggled(first_reg, flash_dq_in)) begin
               pass_next = 1'b1;
               st_next = FWSP_DONE;
               bus_next = BUS_IDLE;
            end else if (flash_dq_in[`FWSP_BIT_TOUT]) begin
               st_next = FWSP_RECHK1;
            end else begin
               // keep polling from the double read
               st_next = FWSP_RD1;
            end
         end
         FWSP_RECHK2: if (cycle_end) begin
            last_next = flash_dq_in;
            if (toggled(first_reg, flash_dq_in)) begin
               fail_next = 1'b1;
               st_next = FWSP_RESET_WR;
               bus_next = cyc(1'b1, addr_reg, `FWSP_CMD_RESET);
            end else begin
               pass_next = 1'b1;
               st_next = FWSP_DONE;
               bus_next = BUS_IDLE;
            end
         end
         FWSP_RESET_WR: if (cycle_end) begin
            st_next = FWSP_DONE;
            bus_next = BUS_IDLE;
         end
         FWSP_TMR_RD: if (cycle_end) begin
            tmr_next = flash_dq_in[`FWSP_BIT_ETMR];
            if (flash_dq_in[`FWSP_BIT_ETMR]) begin
               // window closed, added command would be ignored
               rej_next = 1'b1;
               st_next = FWSP_DONE;
               bus_next = BUS_IDLE;
            end else begin
               // add sector erase inside the window
               st_next = FWSP_ADD_WR;
               bus_next = cyc(1'b1, addr_reg, `FWSP_CMD_SECERASE);
            end
         end
         FWSP_ADD_WR: if (cycle_end) begin
            st_next = FWSP_TMR_RD2;
            bus_next = cyc(1'b0, addr_reg, 8'h0);
         end
         FWSP_TMR_RD2: if (cycle_end) begin
            // high after the command means possibly rejected
            tmr_next = flash_dq_in[`FWSP_BIT_ETMR];
            rej_next = flash_dq_in[`FWSP_BIT_ETMR];
            st_next = FWSP_DONE;
            bus_next = BUS_IDLE;
         end
         FWSP_DONE: begin
            st_next = FWSP_IDLE;
            bus_next = BUS_IDLE;
         end
         default: begin
            st_next = FWSP_IDLE;
            bus_next = BUS_IDLE;
         end
      endcase
      // one clock with strobes high between bus cycles, so every read
      // is a separate strobe and the toggle bit advances once per read
      if (cycle_end && st_reg != FWSP_IDLE) begin
         bus_next.oe_n = 1'b1;
         bus_next.we_n = 1'b1;
      end else if (cnt_reg == 8'h0 && st_reg != FWSP_IDLE &&
                   st_reg != FWSP_DONE && !bus_reg.ce_n) begin
         bus_next.oe_n = bus_reg.dout_en;
         bus_next.we_n = !bus_reg.dout_en;
      end
      if (st_reg == FWSP_IDLE && sw_wr && sw_addr == `FWSP_OFF_ADDR) begin
         addr_next = sw_wdata[21:0];
      end
   end

   // software read mux
   always_comb begin
      rdata_next = 32'h0;
      if (sw_rd) begin
         unique case (sw_addr)
            `FWSP_OFF_ADDR: rdata_next = {10'h0, addr_reg};
            `FWSP_OFF_STAT: begin
               rdata_next[`FWSP_ST_BUSY] = (st_reg != FWSP_IDLE);
               rdata_next[`FWSP_ST_PASS] = pass_reg;
               rdata_next[`FWSP_ST_FAIL] = fail_reg;
               rdata_next[`FWSP_ST_TIMER] = tmr_reg;
               rdata_next[`FWSP_ST_REJECT] = rej_reg;
               rdata_next[`FWSP_ST_RDY] = rdy_reg;
            end
            `FWSP_OFF_DATA: rdata_next = {16'h0, first_reg, last_reg};
            default: rdata_next = 32'h0;
         endcase
      end
   end

   // state registers
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= FWSP_IDLE;
         bus_reg <= BUS_IDLE;
         cnt_reg <= 8'h0;
         first_reg <= 8'h0;
         last_reg <= 8'h0;
         addr_reg <= 22'h0;
         pass_reg <= 1'b0;
         fail_reg <= 1'b0;
         tmr_reg <= 1'b0;
         rej_reg <= 1'b0;
         rdy_reg <= 1'b0;
         sw_rdata <= 32'h0;
      end else begin
         st_reg <= st_next;
         bus_reg <= bus_next;
         cnt_reg <= cnt_next;
         first_reg <= first_next;
         last_reg <= last_next;
         addr_reg <= addr_next;
         pass_reg <= pass_next;
         fail_reg <= fail_next;
         tmr_reg <= tmr_next;
         rej_reg <= rej_next;
         rdy_reg <= rdy_next;
         sw_rdata <= rdata_next;
      end
   end

   // flash pins straight from the bus register
   assign flash_ce_n = bus_reg.ce_n;
   assign flash_oe_n = bus_reg.oe_n;
   assign flash_we_n = bus_reg.we_n;
   assign flash_addr = bus_reg.addr;
   assign flash_dq_out = bus_reg.dout;
   assign flash_dq_oe = bus_reg.dout_en;
endmodule

/* File: include/fwsp_consts.svh */
`ifndef FWSP_CONSTS_SVH
`define FWSP_CONSTS_SVH
// software register offsets (word index on the local port)
`define FWSP_OFF_CTRL 4'h0
`define FWSP_OFF_ADDR 4'h1
`define FWSP_OFF_STAT 4'h2
`define FWSP_OFF_DATA 4'h3
// control register fields
`define FWSP_CTRL_GO 0
`define FWSP_CTRL_TIMER 1
`define FWSP_CTRL_ADDSEC 2
// status register fields
`define FWSP_ST_BUSY 0
`define FWSP_ST_PASS 1
`define FWSP_ST_FAIL 2
`define FWSP_ST_TIMER 3
`define FWSP_ST_REJECT 4
`define FWSP_ST_RDY 5
// status bit positions on the flash data bus
`define FWSP_BIT_POLL 7
`define FWSP_BIT_TOG1 6
`define FWSP_BIT_TOUT 5
`define FWSP_BIT_ETMR 3
`define FWSP_BIT_TOG2 2
// flash command codes
`define FWSP_CMD_RESET 8'hF0
`define FWSP_CMD_SECERASE 8'h30
// bus cycle timing
`define FWSP_CYC_NS 20
`define FWSP_RD_NS 100
`define FWSP_RD_CYC ((`FWSP_RD_NS + `FWSP_CYC_NS - 1) / `FWSP_CYC_NS)
// erase window: 50 us
`define FWSP_WIN_US 50
`define FWSP_WIN_CYC ((`FWSP_WIN_US * 1000) / `FWSP_CYC_NS)
`endif

/* File: include/fwsp_pkg.sv */
package fwsp_pkg;
   typedef enum logic [3:0] {
      FWSP_IDLE, FWSP_RD1, FWSP_RD2, FWSP_RECHK1, FWSP_RECHK2,
      FWSP_RESET_WR, FWSP_DONE, FWSP_TMR_RD, FWSP_ADD_WR, FWSP_TMR_RD2
   } fwsp_state_e;
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [21:0] addr;
      logic [7:0] dout;
      logic dout_en;
   } fwsp_bus_s;
endpackage

/* File: test/fwsp_flash_model.sv */
`timescale 1ns/100ps
module fwsp_flash_model (
   input wire logic clk,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic [7:0] flash_dq_out,
   input wire logic ld,
   input wire logic [7:0] ld_cnt,
   input wire logic ld_fail,
   input wire logic ld_tmr,
   output logic [7:0] flash_dq_in,
   output logic ready_busy_output,
   output logic [7:0] last_cmd = 8'h00
);
   logic [7:0] cnt = 8'h00, wd = 8'h00;
   logic tog = 1'b0, fl = 1'b0, tm = 1'b0, rd_q = 1'b0, we_q = 1'b1;
   wire rd = !flash_ce_n && !flash_oe_n;
   // status while busy, array data when done
   wire [7:0] st = cnt != 8'h00 ? {1'b0, tog, fl, 1'b0, tm, tog, 2'b00} : 8'hA5;
   // busy while the algorithm runs, ready once it ends
   // released bus shows inverse
   assign ready_busy_output = cnt == 8'h00;
   assign flash_dq_in = rd ? st : ~st;
   // one read cycle per strobe edge, commands taken at write end
   always @(posedge clk) begin
      rd_q <= rd;
      we_q <= flash_we_n;
      if (!flash_we_n) wd <= flash_dq_out;
      if (ld) begin
         cnt <= ld_cnt;
         fl <= ld_fail;
         tm <= ld_tmr;
      // toggle per read, a halted job never ends
      end else if (rd && !rd_q && cnt != 8'h00) begin
         tog <= !tog;
         if (!fl) cnt <= cnt - 8'h01;
      // reset command returns to array read
      end else if (flash_we_n && !we_q && wd == 8'hF0) begin
         cnt <= 8'h00;
         fl <= 1'b0;
         last_cmd <= wd;
      // added erase taken only while the window is open
      end else if (flash_we_n && !we_q && !tm) begin
         last_cmd <= wd;
      end
   end
endmodule

/* File: test/fwsp_poller_sva.sv */
`timescale 1ns/100ps
module fwsp_poller_chk #(parameter int RD_CYC = 5) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   input wire logic [31:0] sw_rdata,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic [21:0] flash_addr,
   input wire logic [7:0] flash_dq_out,
   input wire logic flash_dq_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // a toggle poll ordered while the flash bus is idle
   sequence s_start;
      sw_wr && sw_addr == 4'h0 && sw_wdata[0] && flash_ce_n;
   endsequence
   // one whole read cycle of five clocks
   sequence s_read;
      (!flash_ce_n && !flash_oe_n) [*5];
   endsequence
   chk_first_read: assert property (s_start |=> s_read)
      else $error("poll did not open with a read");
   chk_addr_hold: assert property (!flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr))
      else $error("address moved during a read");
   chk_read_quiet: assert property (!flash_oe_n |-> flash_we_n && !flash_dq_oe)
      else $error("host drove data during a read");
   chk_ce_cover: assert property (!flash_oe_n || !flash_we_n |-> !flash_ce_n)
      else $error("strobe without chip enable");
   chk_cmd_code: assert property ($fell(flash_we_n) |-> flash_dq_oe && (flash_dq_out == 8'hF0 || flash_dq_out == 8'h30))
      else $error("unexpected command byte");
   chk_wr_short: assert property ($fell(flash_we_n) |-> ##[1:8] flash_we_n)
      else $error("write strobe stuck low");
   chk_wr_data: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_out) && flash_dq_oe)
      else $error("write data moved in a write");
   chk_rdata_idle: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
      else $error("read data outside answer cycle");
endmodule
bind fwsp_poller fwsp_poller_chk #(.RD_CYC(RD_CYC)) chk_u (.*);

/* File: test/fwsp_poller_test.sv */
`timescale 1ns/100ps
module fwsp_poller_test;
   logic clk = 1'b0, rst = 1'b1, sw_wr = 1'b0, sw_rd = 1'b0, ld = 1'b0;
   logic ld_fail = 1'b0, ld_tmr = 1'b0, flash_ce_n, flash_oe_n, flash_we_n;
   logic flash_dq_oe, ready_busy_output;
   logic [3:0] sw_addr = 4'h0;
   logic [31:0] sw_wdata = 32'h0, sw_rdata, v;
   logic [7:0] ld_cnt = 8'h00, flash_dq_out, flash_dq_in, last_cmd;
   logic [21:0] flash_addr;
   logic [2:0] s;
   int err_count = 0, n_tests = 0;
   always #10 clk = ~clk;
   fwsp_poller #(.RD_CYC(5)) dut_u (.*);
   fwsp_flash_model flash_u (.*);
   // compare and count
   task automatic check(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // one write (w=1) or read (w=0) on the register port
   task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= w;
      sw_rd <= !w;
      @(posedge clk);
      sw_wr <= 1'b0;
      sw_rd <= 1'b0;
      @(negedge clk);
      v = sw_rdata;
   endtask
   // set the flash state, start a job, wait for it, check the outcome
   task automatic run(input logic [31:0] c0, input logic [7:0] n,
      input logic f, t, input logic [2:0] e, input logic [7:0] c);
      int k;
      @(posedge clk);
      ld_cnt <= n;
      ld_fail <= f;
      ld_tmr <= t;
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      bus(4'h1, 32'h00012345, 1'b1);
      bus(4'h0, c0, 1'b1);
      bus(4'h1, 32'h0000ABCD, 1'b1);
      k = 0;
      do begin
         bus(4'h2, 32'h0, 1'b0);
         k++;
      end while (v[0] !== 1'b0 && k < 300);
      check({31'h0, k >= 300}, 32'h0);
      bus(4'h2, 32'h0, 1'b0);
      s = {v[5], v[2], c0[1] ? v[4] : v[1]};
      check({29'h0, s}, {29'h0, e});
      check({24'h0, last_cmd}, {24'h0, c});
      bus(4'h1, 32'h0, 1'b0);
      check(v, 32'h00012345);
      $display("test done ctrl %h", c0);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // reset, then the scenarios
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      run(32'h1, 8'h00, 1'b0, 1'b0, 3'b101, 8'h00);
      run(32'h1, 8'h06, 1'b0, 1'b0, 3'b101, 8'h00);
      run(32'h2, 8'h04, 1'b0, 1'b1, 3'b001, 8'h00);
      run(32'h2, 8'h04, 1'b0, 1'b0, 3'b000, 8'h30);
      run(32'h1, 8'h03, 1'b1, 1'b0, 3'b110, 8'hF0);
      wrap_up;
   end
   // watchdog well beyond the expected run length
   initial begin
      #800000;
      err_count++;
      wrap_up;
   end
endmodule
